// [rtl/tmfp_pins.sv]
// Multi-function pins of the tuner: straps, general I/O, interrupt and stereo outputs
`default_nettype none

module tmfp_pins
	import tmfp_pkg::*;
#(
	parameter int unsigned POWERUP_CNT = tmfp_pkg::POWERUP_CYCLES,
	parameter int unsigned IRQ_PULSE_CNT = tmfp_pkg::IRQ_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [tmfp_pkg::ADDR_W-1:0] addr,
	input wire logic [tmfp_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [tmfp_pkg::DATA_W-1:0] rdata,
	input wire logic multi_pin_one_in,
	output logic multi_pin_one_out,
	output logic multi_pin_one_oe,
	input wire logic multi_pin_two_irq_in,
	output logic multi_pin_two_irq_out,
	output logic multi_pin_two_irq_oe,
	input wire logic multi_pin_three_stereo_in,
	output logic multi_pin_three_stereo_out,
	output logic multi_pin_three_stereo_oe,
	output logic pin_three_pull_down_en,
	output logic [1:0] bus_mode_straps,
	output logic bus_mode_valid,
	input wire logic tune_done_set,
	input wire logic tune_done_ack,
	input wire logic rds_ready_set,
	input wire logic stereo_ind,
	output logic tune_done_flag,
	output logic powered_up,
	output logic irq
);
	import tmfp_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [PIN_N-1:0] pin_in, pin_sync1_reg, pin_sync2_reg;
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [PIN_CFG_W-1:0] pin_cfg_reg, pin_cfg_next;
	logic [IRQ_W-1:0] irq_en_reg, irq_en_next;
	logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
	logic tune_flag_reg, tune_flag_next;
	logic [1:0] strap_reg, strap_next;
	logic [1:0] strap_cnt_reg, strap_cnt_next;
	logic strap_done_reg, strap_done_next;
	logic pull_down_reg, pull_down_next;
	tmfp_pwr_e pwr_reg, pwr_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [PIN_N-1:0] pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;
	logic [PIN_N-1:0] spec_out, spec_oe;
	logic [PIN_N-1:0] status_pins;
	logic wr_ctrl, wr_cfg, wr_clr, wr_en, enable_rise;
	logic pwr_start, pwr_abort, pwr_done;
	logic pulse_start, pulse_busy, tune_event, irq_src;

	assign pin_in = {multi_pin_three_stereo_in, multi_pin_two_irq_in, multi_pin_one_in};

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pin_sync1_reg <= '0;
			pin_sync2_reg <= '0;
		end
		else
		begin
			pin_sync1_reg <= pin_in;
			pin_sync2_reg <= pin_sync1_reg;
		end
	end

	assign status_pins = pin_sync2_reg;

	// ------------------------------------------------------------
	// Bus mode straps and reset pull-down
	// ------------------------------------------------------------
	always_comb
	begin
		strap_next = strap_reg;
		strap_cnt_next = strap_cnt_reg;
		strap_done_next = strap_done_reg;
		pull_down_next = 1'b0;
		if (!strap_done_reg)
		begin
			if (strap_cnt_reg == STRAP_WAIT)
			begin
				strap_next = {pin_sync2_reg[2], pin_sync2_reg[0]};
				strap_done_next = 1'b1;
			end
			else
			begin
				strap_cnt_next = strap_cnt_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			strap_reg <= 2'h0;
			strap_cnt_reg <= 2'h0;
			strap_done_reg <= 1'b0;
			pull_down_reg <= 1'b1;
		end
		else
		begin
			strap_reg <= strap_next;
			strap_cnt_reg <= strap_cnt_next;
			strap_done_reg <= strap_done_next;
			pull_down_reg <= pull_down_next;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	assign wr_ctrl = wr && addr == OFF_CTRL;
	assign wr_cfg = wr && addr == OFF_PIN_CFG;
	assign wr_clr = wr && addr == OFF_IRQ_CLR;
	assign wr_en = wr && addr == OFF_IRQ_EN;
	assign enable_rise = wr_ctrl && wdata[CTRL_ENABLE] && !ctrl_reg[CTRL_ENABLE];
	assign tune_event = tune_done_set && !tune_flag_reg;

	always_comb
	begin
		ctrl_next = wr_ctrl ? wdata[CTRL_W-1:0] : ctrl_reg;
		pin_cfg_next = wr_cfg ? wdata[PIN_CFG_W-1:0] : pin_cfg_reg;
		irq_en_next = wr_en ? wdata[IRQ_W-1:0] : irq_en_reg;
		irq_stat_next = irq_stat_reg;
		if (wr_clr)
		begin
			irq_stat_next = irq_stat_reg & ~wdata[IRQ_W-1:0];
		end
		if (tune_event)
		begin
			irq_stat_next[IRQ_TUNE] = 1'b1;
		end
		if (pwr_done)
		begin
			irq_stat_next[IRQ_POWERUP] = 1'b1;
		end
		if (rds_ready_set)
		begin
			irq_stat_next[IRQ_RDS] = 1'b1;
		end
		tune_flag_next = tune_flag_reg;
		if (tune_done_set)
		begin
			tune_flag_next = 1'b1;
		end
		else if (tune_done_ack)
		begin
			tune_flag_next = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl_reg <= CTRL_RESET;
			pin_cfg_reg <= PIN_CFG_RESET;
			irq_en_reg <= IRQ_RESET;
			irq_stat_reg <= IRQ_RESET;
			tune_flag_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			pin_cfg_reg <= pin_cfg_next;
			irq_en_reg <= irq_en_next;
			irq_stat_reg <= irq_stat_next;
			tune_flag_reg <= tune_flag_next;
		end
	end

	// ------------------------------------------------------------
	// Powerup sequence
	// ------------------------------------------------------------
	always_comb
	begin
		pwr_next = pwr_reg;
		pwr_start = 1'b0;
		pwr_abort = 1'b0;
		unique case (pwr_reg)
			PWR_OFF:
			begin
				if (enable_rise && !wdata[CTRL_DISABLE])
				begin
					pwr_next = PWR_WAKE;
					pwr_start = 1'b1;
				end
			end
			PWR_WAKE:
			begin
				if (ctrl_reg[CTRL_DISABLE] || !ctrl_reg[CTRL_ENABLE])
				begin
					pwr_next = PWR_OFF;
					pwr_abort = 1'b1;
				end
				else if (pwr_done)
				begin
					pwr_next = PWR_ON;
				end
			end
			PWR_ON:
			begin
				if (ctrl_reg[CTRL_DISABLE] || !ctrl_reg[CTRL_ENABLE])
				begin
					pwr_next = PWR_OFF;
				end
			end
			default:
			begin
				pwr_next = PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pwr_reg <= PWR_OFF;
		end
		else
		begin
			pwr_reg <= pwr_next;
		end
	end

	tmfp_pulse_timer #(
		.CNT_W(CNT_W),
		.COUNT(POWERUP_CNT)
	) u_pwr_timer (
		.clk(clk),
		.reset(reset),
		.start(pwr_start),
		.abort(pwr_abort),
		.busy(),
		.done(pwr_done)
	);

	// ------------------------------------------------------------
	// Interrupt pulse on pin two
	// ------------------------------------------------------------
	assign irq_src = (tune_event && ctrl_reg[CTRL_TUNE_IRQ])
		|| (rds_ready_set && ctrl_reg[CTRL_RDS_IRQ]);
	assign pulse_start = irq_src && pin_cfg_reg[3:2] == FN_SPECIAL
		&& pwr_reg == PWR_ON && !pulse_busy;

	tmfp_pulse_timer #(
		.CNT_W(CNT_W),
		.COUNT(IRQ_PULSE_CNT)
	) u_irq_timer (
		.clk(clk),
		.reset(reset),
		.start(pulse_start),
		.abort(1'b0),
		.busy(pulse_busy),
		.done()
	);

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	assign spec_out = {stereo_ind, !pulse_busy, 1'b0};
	assign spec_oe = {1'b1, 1'b1, 1'b0};

	for (genvar i = 0; i < PIN_N; i++)
	begin : g_pin
		always_comb
		begin
			pin_out_next[i] = 1'b0;
			pin_oe_next[i] = 1'b0;
			unique case (pin_cfg_reg[2*i +: 2])
				FN_HIZ:
				begin
					pin_oe_next[i] = 1'b0;
				end
				FN_SPECIAL:
				begin
					pin_out_next[i] = spec_out[i];
					pin_oe_next[i] = spec_oe[i];
				end
				FN_LOW:
				begin
					pin_oe_next[i] = 1'b1;
				end
				FN_HIGH:
				begin
					pin_out_next[i] = 1'b1;
					pin_oe_next[i] = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pin_out_reg <= '0;
			pin_oe_reg <= '0;
		end
		else
		begin
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	always_comb
	begin
		rdata_next = '0;
		if (rd)
		begin
			unique case (addr)
				OFF_CTRL: rdata_next[CTRL_W-1:0] = ctrl_reg;
				OFF_PIN_CFG: rdata_next[PIN_CFG_W-1:0] = pin_cfg_reg;
				OFF_STATUS:
				begin
					rdata_next[ST_PINS +: PIN_N] = status_pins;
					rdata_next[ST_STRAPS +: 2] = strap_reg;
					rdata_next[ST_STRAP_DONE] = strap_done_reg;
					rdata_next[ST_POWERED] = pwr_reg == PWR_ON;
					rdata_next[ST_TUNE_FLAG] = tune_flag_reg;
				end
				OFF_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_reg;
				OFF_IRQ_EN: rdata_next[IRQ_W-1:0] = irq_en_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rdata_reg <= '0;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata = rdata_reg;
	assign {multi_pin_three_stereo_out, multi_pin_two_irq_out, multi_pin_one_out} = pin_out_reg;
	assign {multi_pin_three_stereo_oe, multi_pin_two_irq_oe, multi_pin_one_oe} = pin_oe_reg;
	assign pin_three_pull_down_en = pull_down_reg;
	assign bus_mode_straps = strap_reg;
	assign bus_mode_valid = strap_done_reg;
	assign tune_done_flag = tune_flag_reg;
	assign powered_up = pwr_reg == PWR_ON;
	assign irq = |(irq_stat_reg & irq_en_reg);
endmodule : tmfp_pins

`default_nettype wire

// [rtl/tmfp_pkg.sv]
// Constants shared by the tuner multi-function pin block
`default_nettype none

package tmfp_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
	localparam int unsigned POWERUP_TIME_MS = 110;
	localparam int unsigned POWERUP_CYCLES = POWERUP_TIME_MS * CLK_PER_MS;
	localparam int unsigned IRQ_PULSE_TIME_MS = 5;
	localparam int unsigned IRQ_PULSE_CYCLES = IRQ_PULSE_TIME_MS * CLK_PER_MS;
	localparam int unsigned CNT_W = 22;
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PIN_CFG = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFF_IRQ_EN = 8'h14;

	// Control register fields
	localparam int unsigned CTRL_W = 4;
	localparam int unsigned CTRL_ENABLE = 0;
	localparam int unsigned CTRL_DISABLE = 1;
	localparam int unsigned CTRL_TUNE_IRQ = 2;
	localparam int unsigned CTRL_RDS_IRQ = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Pin configuration: two bits per pin in the low six bits
	localparam int unsigned PIN_N = 3;
	localparam int unsigned PIN_CFG_W = 6;
	localparam logic [5:0] PIN_CFG_RESET = 6'h00;
	localparam logic [1:0] FN_HIZ = 2'h0;
	localparam logic [1:0] FN_SPECIAL = 2'h1;
	localparam logic [1:0] FN_LOW = 2'h2;
	localparam logic [1:0] FN_HIGH = 2'h3;

	// Status register fields
	localparam int unsigned ST_PINS = 0;
	localparam int unsigned ST_STRAPS = 3;
	localparam int unsigned ST_STRAP_DONE = 5;
	localparam int unsigned ST_POWERED = 6;
	localparam int unsigned ST_TUNE_FLAG = 7;

	// Interrupt status, clear and enable layout
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_TUNE = 0;
	localparam int unsigned IRQ_POWERUP = 1;
	localparam int unsigned IRQ_RDS = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// Power state
	typedef enum logic [2:0]
	{
		PWR_OFF = 3'b001,
		PWR_WAKE = 3'b010,
		PWR_ON = 3'b100
	} tmfp_pwr_e;
endpackage : tmfp_pkg

`default_nettype wire

// [rtl/tmfp_pulse_timer.sv]
// One-shot cycle timer used for the powerup wait and the interrupt pulse
`default_nettype none

module tmfp_pulse_timer #(
	parameter int unsigned CNT_W = 22,
	parameter int unsigned COUNT = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic abort,
	output logic busy,
	output logic done
);
	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (COUNT < 1 || COUNT > (2 ** CNT_W))
	begin : g_bad
		$error("timer count does not fit the counter");
	end

	localparam logic [CNT_W-1:0] LOAD = CNT_W'(COUNT - 1);

	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_comb
	begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done = 1'b0;
		if (abort)
		begin
			busy_next = 1'b0;
		end
		else if (start)
		begin
			cnt_next = LOAD;
			busy_next = 1'b1;
		end
		else if (busy_reg)
		begin
			if (cnt_reg == '0)
			begin
				busy_next = 1'b0;
				done = 1'b1;
			end
			else
			begin
				cnt_next = cnt_reg - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
		end
	end

	assign busy = busy_reg;
endmodule : tmfp_pulse_timer

`default_nettype wire

// [test/tb_tmfp_pins.sv]
// Self-checking bench for the tuner multi-function pins
`default_nettype none

module tb_tmfp_pins
	import tmfp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PU = 20;
	localparam int PL = 8;
	logic clk, reset, wr, rd, pd, valid, tset, tack, rset, stereo, flag, pwr, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, v;
	logic [2:0] out, oe, pin, hl;
	logic [1:0] straps;
	logic [5:0] cfg;
	logic [7:0] offs [6] = '{OFF_CTRL, OFF_PIN_CFG, OFF_IRQ_STAT, OFF_IRQ_CLR, OFF_IRQ_EN, 8'h40};
	int low_len, pulses, n;
	int bad_count = 0;
	int checks = 0;

	tmfp_pins #(.POWERUP_CNT(PU), .IRQ_PULSE_CNT(PL)) tmfp_pins_i (
		.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .multi_pin_one_in(pin[0]), .multi_pin_one_out(out[0]),
		.multi_pin_one_oe(oe[0]), .multi_pin_two_irq_in(pin[1]),
		.multi_pin_two_irq_out(out[1]), .multi_pin_two_irq_oe(oe[1]),
		.multi_pin_three_stereo_in(pin[2]), .multi_pin_three_stereo_out(out[2]),
		.multi_pin_three_stereo_oe(oe[2]), .pin_three_pull_down_en(pd),
		.bus_mode_straps(straps), .bus_mode_valid(valid), .tune_done_set(tset),
		.tune_done_ack(tack), .rds_ready_set(rset), .stereo_ind(stereo),
		.tune_done_flag(flag), .powered_up(pwr), .irq(irq)
	);
	tmfp_host_model host_i (.clk(clk), .host_lvl(hl), .dev_out(out), .dev_oe(oe),
		.pin(pin), .low_len(low_len), .pulses(pulses));

	// ----------------
	// Bus and compare tasks
	// ----------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wreg
	task automatic rreg(input logic [7:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge clk);
	endtask : rreg
	function automatic logic [2:0] exp_oe(input logic [5:0] c);
		return {c[5], c[3], c[1]};
	endfunction : exp_oe
	function automatic logic [2:0] exp_lvl(input logic [5:0] c, input logic [2:0] h);
		return (exp_oe(c) & {c[4], c[2], c[0]}) | (~exp_oe(c) & h);
	endfunction : exp_lvl
	task automatic results;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		bad_count++;
		results();
	end

	// ----------------
	// Tests
	// ----------------
	initial
	begin
		{reset, wr, rd, tset, tack, rset, stereo} = 7'h40;
		addr = 8'h00;
		wdata = 32'h0;
		hl = 3'h1;
		void'($urandom(32'hf3b43897));
		repeat (4) @(posedge clk);
		chk(pd, 1'b1);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		chk({pd, valid, straps, oe}, 7'h28);
		foreach (offs[i])
		begin
			rreg(offs[i]);
			chk(v, 32'h0);
		end
		$display("reset test done");
		for (int k = 0; k < 6; k++)
		begin
			cfg = (k == 0) ? 6'h23 : 6'($urandom);
			for (int i = 0; i < 3; i++)
				if (cfg[2*i +: 2] == FN_SPECIAL)
					cfg[2*i +: 2] = FN_HIZ;
			hl <= 3'($urandom);
			wreg(OFF_PIN_CFG, {26'h0, cfg});
			repeat (2) @(posedge clk);
			chk(oe, exp_oe(cfg));
			rreg(OFF_STATUS);
			chk(v[2:0], exp_lvl(cfg, hl));
		end
		$display("general io test done");
		wreg(OFF_IRQ_EN, 32'h7);
		wreg(OFF_CTRL, 32'h1);
		n = 1;
		#1;
		while (pwr !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n, PU);
		@(posedge clk);
		rreg(OFF_IRQ_STAT);
		chk(irq, 1'b1);
		chk(v, 32'h2);
		wreg(OFF_IRQ_EN, 32'h0);
		chk(irq, 1'b0);
		wreg(OFF_IRQ_EN, 32'h7);
		chk(irq, 1'b1);
		wreg(OFF_IRQ_CLR, 32'h2);
		chk(irq, 1'b0);
		$display("powerup test done");
		wreg(OFF_CTRL, 32'h5);
		wreg(OFF_PIN_CFG, 32'h14);
		stereo <= 1'($urandom);
		repeat (3) @(posedge clk);
		n = pulses;
		chk({pin[2:1], oe}, {stereo, 4'he});
		for (int i = 0; i < 2; i++)
		begin
			tset <= 1'b1;
			@(posedge clk);
			tset <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (12) @(posedge clk);
		chk(flag, 1'b1);
		chk(pulses - n, 1);
		chk(low_len, PL);
		tack <= 1'b1;
		@(posedge clk);
		tack <= 1'b0;
		wreg(OFF_CTRL, 32'hd);
		chk(flag, 1'b0);
		rset <= 1'b1;
		@(posedge clk);
		rset <= 1'b0;
		repeat (14) @(posedge clk);
		chk(pulses - n, 2);
		chk(low_len, PL);
		$display("interrupt pulse test done");
		wreg(OFF_CTRL, 32'h2);
		wreg(OFF_PIN_CFG, 32'h3f);
		repeat (2) @(posedge clk);
		chk({pwr, oe, out}, 7'h3f);
		$display("disabled io test done");
		wreg(OFF_PIN_CFG, 32'h1);
		wreg(OFF_CTRL, 32'h1);
		wreg(OFF_CTRL, 32'h0);
		repeat (PU + 4) @(posedge clk);
		chk({pwr, oe}, 4'h0);
		rreg(OFF_IRQ_STAT);
		chk(v, 32'h5);
		$display("powerup abort test done");
		results();
	end
endmodule : tb_tmfp_pins

`default_nettype wire

// [test/tmfp_host_model.sv]
// Host side of the pins: strap levels, wire resolution, pulse timing
`default_nettype none

module tmfp_host_model (
	input wire logic clk,
	input wire logic [2:0] host_lvl,
	input wire logic [2:0] dev_out,
	input wire logic [2:0] dev_oe,
	output logic [2:0] pin,
	output int low_len,
	output int pulses
);
	timeunit 1ns;
	timeprecision 1ns;
	int run = 0;

	// Device drive wins, else host level holds the straps
	assign pin = (dev_oe & dev_out) | (~dev_oe & host_lvl);
	initial
	begin
		low_len = 0;
		pulses = 0;
	end
	// Times each driven low stretch on pin two
	always @(posedge clk)
		if (dev_oe[1] && !dev_out[1])
			run <= run + 1;
		else if (run != 0)
		begin
			low_len <= run;
			pulses <= pulses + 1;
			run <= 0;
		end
endmodule : tmfp_host_model

`default_nettype wire

// [test/tmfp_pins_checker.sv]
// Port-level assertions for the multi-function pin block
`default_nettype none

module tmfp_pins_checker
	import tmfp_pkg::*;
#(
	parameter int unsigned POWERUP_CNT = 20,
	parameter int unsigned IRQ_PULSE_CNT = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [tmfp_pkg::ADDR_W-1:0] addr,
	input wire logic [tmfp_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [tmfp_pkg::DATA_W-1:0] rdata,
	input wire logic multi_pin_one_out,
	input wire logic multi_pin_one_oe,
	input wire logic multi_pin_two_irq_out,
	input wire logic multi_pin_two_irq_oe,
	input wire logic multi_pin_three_stereo_out,
	input wire logic multi_pin_three_stereo_oe,
	input wire logic pin_three_pull_down_en,
	input wire logic [1:0] bus_mode_straps,
	input wire logic bus_mode_valid,
	input wire logic tune_done_set,
	input wire logic tune_done_flag,
	input wire logic powered_up,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] low_reg;
	logic [23:0] low_next;
	logic pu_wr;
	logic cfg_wr;

	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);

	// ----------------
	// Helper logic
	// ----------------
	// Low time of pin two while driven
	assign pu_wr = wr && addr == OFF_CTRL && wdata[CTRL_ENABLE] && !wdata[CTRL_DISABLE];
	assign cfg_wr = wr && addr == OFF_PIN_CFG;
	always_comb
	begin
		low_next = 24'h0;
		if (multi_pin_two_irq_oe && !multi_pin_two_irq_out)
			low_next = low_reg + 24'h1;
	end
	always_ff @(posedge clk or posedge reset)
		if (reset)
			low_reg <= 24'h0;
		else
			low_reg <= low_next;

	// ----------------
	// Assertions
	// ----------------
	pd_reset_a: assert property (disable iff (1'b0) reset |-> pin_three_pull_down_en)
		else $error("pull-down off during reset");
	pd_release_a: assert property (!$past(reset) |-> !pin_three_pull_down_en)
		else $error("pull-down on after reset");
	strap_hold_a: assert property (bus_mode_valid |=> bus_mode_valid && $stable(bus_mode_straps))
		else $error("bus mode straps changed");
	pin_high_a: assert property (cfg_wr && wdata[1:0] == FN_HIGH |->
		##2 multi_pin_one_oe && multi_pin_one_out)
		else $error("pin one not driven high");
	pin_low_a: assert property (cfg_wr && wdata[5:4] == FN_LOW |->
		##2 multi_pin_three_stereo_oe && !multi_pin_three_stereo_out)
		else $error("pin three not driven low");
	pin_hiz_a: assert property (cfg_wr && wdata[3:2] == FN_HIZ |-> ##2 !multi_pin_two_irq_oe)
		else $error("pin two driven while undriven");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside read slot");
	irq_mask_a: assert property (wr && addr == OFF_IRQ_EN && wdata[2:0] == IRQ_RESET |=> !irq)
		else $error("interrupt high while masked");
	flag_set_a: assert property (tune_done_set |=> tune_done_flag)
		else $error("tune done flag not set");
	powerup_time_a: assert property ($rose(powered_up) |-> $past(pu_wr, POWERUP_CNT + 1))
		else $error("powerup time wrong");
	pulse_len_a: assert property ($rose(multi_pin_two_irq_out) && $past(multi_pin_two_irq_oe)
		&& !$past(wr, 2) |-> low_reg == IRQ_PULSE_CNT)
		else $error("interrupt pulse length wrong");
endmodule : tmfp_pins_checker

bind tmfp_pins tmfp_pins_checker #(.POWERUP_CNT(POWERUP_CNT), .IRQ_PULSE_CNT(IRQ_PULSE_CNT))
	tmfp_pins_checker_i (.*);

`default_nettype wire
